// ===== rtl/mma_pkg.sv
// constants and types of the memory-mapped multiply-accumulate unit
package mma_pkg;
    localparam int ADDR_W = 5;
    localparam logic [4:0] OP1_UNSIGNED_MUL_16 = 5'h00;
    localparam logic [4:0] OP1_SIGNED_MUL_16 = 5'h01;
    localparam logic [4:0] OP1_UNSIGNED_ACC_16 = 5'h02;
    localparam logic [4:0] OP1_SIGNED_ACC_16 = 5'h03;
    localparam logic [4:0] OP1_UNSIGNED_MUL_LOW = 5'h04;
    localparam logic [4:0] OP1_UNSIGNED_MUL_HIGH = 5'h05;
    localparam logic [4:0] OP1_SIGNED_MUL_LOW = 5'h06;
    localparam logic [4:0] OP1_SIGNED_MUL_HIGH = 5'h07;
    localparam logic [4:0] OP1_UNSIGNED_ACC_LOW = 5'h08;
    localparam logic [4:0] OP1_UNSIGNED_ACC_HIGH = 5'h09;
    localparam logic [4:0] OP1_SIGNED_ACC_LOW = 5'h0a;
    localparam logic [4:0] OP1_SIGNED_ACC_HIGH = 5'h0b;
    localparam logic [4:0] OP2_START_16 = 5'h0c;
    localparam logic [4:0] OP2_START_LOW = 5'h0d;
    localparam logic [4:0] OP2_CONTINUE_HIGH = 5'h0e;
    localparam logic [4:0] MULT_CONTROL = 5'h0f;
    localparam logic [4:0] RESULT_WORD_0 = 5'h10;
    localparam logic [4:0] RESULT_WORD_1 = 5'h11;
    localparam logic [4:0] RESULT_WORD_2 = 5'h12;
    localparam logic [4:0] RESULT_WORD_3 = 5'h13;
    localparam logic [4:0] COMPAT_RESULT_LOW = 5'h14;
    localparam logic [4:0] COMPAT_RESULT_HIGH = 5'h15;
    localparam logic [4:0] SUM_EXTENSION = 5'h16;
    // control register fields
    localparam int CTL_DLY_EN = 0;
    localparam int CTL_DLY32 = 1;
    localparam int CTL_CARRY = 2;
    localparam int CTL_DONE_LSB = 8;
    localparam logic CTL_DLY_EN_RST = 1'b0;
    localparam logic CTL_DLY32_RST = 1'b0;
    // readiness in cycles, nibbles {carry, word3, word2, word1, word0}
    localparam logic [19:0] SCH_NARROW_NARROW = 20'h3_4433;
    localparam logic [19:0] SCH_WIDE_NARROW = 20'h7_7653;
    localparam logic [19:0] SCH_NARROW_WIDE_LOW = 20'h7_7653;
    localparam logic [19:0] SCH_NARROW_WIDE_HIGH = 20'h4_4430;
    localparam logic [19:0] SCH_WIDE_WIDE_LOW = 20'hb_ba83;
    localparam logic [19:0] SCH_WIDE_WIDE_HIGH = 20'h6_6530;
    localparam logic [3:0] CNT_MAX = 4'hf;
    localparam logic [3:0] CNT_START = 4'h1;
    localparam logic [15:0] SUM_EXTENSION_NEG = 16'hffff;
    typedef enum logic [1:0] {
        MODE_UMUL = 2'h0,
        MODE_SMUL = 2'h1,
        MODE_UACC = 2'h2,
        MODE_SACC = 2'h3
    } mma_mode_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_WAIT_HIGH = 3'h2,
        ST_RUN = 3'h4
    } mma_state_t;
endpackage

// ===== rtl/mma_core.sv
// multiply-accumulate unit: operand registers, scheduler, results, bus
// Operation
// - width from address and byte access
// - first low word picks mode, no start
// - twelve first-operand write addresses
// - high word last means 32-bit first
// - high before low gives 16-bit first
// - first operand kept across operations
// - 16-bit second write starts operation
// - second low starts, high continues
// - lone second high write ignored
// - signed byte writes sign-extended
// - 24-bit: high byte, low register decides
// - stored high word kept, ignored narrow
// - operand change voids unready words
// - new start aborts, unready not accumulated
// - delayed writes wait for result
// - narrow result ready three cycles
// - wide results readable back to back
// - words ready per fixed schedule
// - later of low/high schedules governs
// - four words plus compat registers
// - sum extension and carry by mode
// - sign/carry from 32 or 64 bits
`timescale 1ns/1ps
`default_nettype none
module mma_core (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // peripheral bus
    input wire logic [mma_pkg::ADDR_W-1:0] bus_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic bus_byte,
    input wire logic [15:0] bus_wdata,
    output logic [15:0] bus_rdata,
    output logic bus_wait
);
    logic [15:0] first_lo_reg, first_lo_next, first_hi_reg, first_hi_next;
    logic first_wide_reg, first_wide_next;
    mma_pkg::mma_mode_t mode_reg, mode_next;
    logic [15:0] second_lo_reg, second_lo_next, second_hi_reg, second_hi_next;
    logic dly_en_reg, dly_en_next, dly32_reg, dly32_next;
    logic [15:0] rdata_reg, rdata_next;
    mma_pkg::mma_state_t state_reg, state_next;
    logic [3:0] cnt_lo_reg, cnt_lo_next, cnt_hi_reg, cnt_hi_next;
    logic [4:0] done_reg, done_next;
    logic [15:0] res_reg [4];
    logic [15:0] res_next [4];
    logic carry_flag_reg, carry_flag_next;
    logic [63:0] base_reg, base_next;
    mma_pkg::mma_mode_t run_mode_reg, run_mode_next;
    logic run_w1_reg, run_w1_next, run_w2_reg, run_w2_next;
    logic hold_reg, hold_next;

    function automatic mma_pkg::mma_mode_t op1_mode(input logic [4:0] a);
        logic [4:0] d;
        d = a - mma_pkg::OP1_UNSIGNED_MUL_LOW;
        if (a < mma_pkg::OP1_UNSIGNED_MUL_LOW) begin
            return mma_pkg::mma_mode_t'(a[1:0]);
        end
        return mma_pkg::mma_mode_t'(d[2:1]);
    endfunction

    function automatic logic is_high(input logic [4:0] a);
        return a >= mma_pkg::OP1_UNSIGNED_MUL_LOW && a[0];
    endfunction

    function automatic logic [63:0] widen(input logic [15:0] hi, input logic [15:0] lo,
                                          input logic wide, input logic sgn);
        logic [31:0] v;
        v = wide ? {hi, lo} : {{16{sgn & lo[15]}}, lo};
        return {{32{sgn & v[31]}}, v};
    endfunction

    function automatic logic [3:0] sat_inc(input logic [3:0] c);
        return (c == mma_pkg::CNT_MAX) ? c : c + 4'h1;
    endfunction

    function automatic logic [19:0] sched_lo(input logic w1, input logic w2);
        if (!w2) begin
            return w1 ? mma_pkg::SCH_WIDE_NARROW : mma_pkg::SCH_NARROW_NARROW;
        end
        return w1 ? mma_pkg::SCH_WIDE_WIDE_LOW : mma_pkg::SCH_NARROW_WIDE_LOW;
    endfunction

    // bus request decode
    logic wr_go, addr_first, addr_high, first_go, first_hi_go;
    logic start16, startlo, start_go, hi_go, quiet;
    assign wr_go = bus_wr && !hold_reg;
    assign addr_first = bus_addr <= mma_pkg::OP1_SIGNED_ACC_HIGH;
    assign addr_high = is_high(bus_addr);
    assign first_go = wr_go && addr_first;
    assign first_hi_go = first_go && addr_high;
    assign start16 = wr_go && bus_addr == mma_pkg::OP2_START_16;
    assign startlo = wr_go && bus_addr == mma_pkg::OP2_START_LOW;
    assign start_go = start16 || startlo;
    assign hi_go = wr_go && bus_addr == mma_pkg::OP2_CONTINUE_HIGH
                   && state_reg == mma_pkg::ST_WAIT_HIGH;
    assign quiet = !start_go && !(first_go && state_reg != mma_pkg::ST_IDLE);

    // datapath
    logic sgn, acc, narrow, carry_calc, res_sign;
    logic [63:0] opa, opb, product, full;
    logic [64:0] sum64;
    logic [32:0] sum32;
    logic [19:0] sch_l, sch_h;
    logic [4:0] ready;
    logic [15:0] sum_extension, ctrl;
    assign sgn = run_mode_reg[0];
    assign acc = run_mode_reg[1];
    assign narrow = !run_w1_reg && !run_w2_reg;
    assign opa = widen(first_hi_reg, first_lo_reg, run_w1_reg, sgn);
    assign opb = widen(second_hi_reg, second_lo_reg, run_w2_reg, sgn);
    assign product = opa * opb;
    assign sum64 = {1'b0, base_reg} + {1'b0, product};
    assign sum32 = {1'b0, base_reg[31:0]} + {1'b0, product[31:0]};
    assign full = acc ? sum64[63:0] : product;
    assign carry_calc = narrow ? (acc ? sum32[32] : sgn & full[31])
                               : (acc ? sum64[64] : sgn & full[63]);
    assign res_sign = narrow ? res_reg[1][15] : res_reg[3][15];
    assign sch_l = sched_lo(run_w1_reg, run_w2_reg);
    assign sch_h = run_w1_reg ? mma_pkg::SCH_WIDE_WIDE_HIGH : mma_pkg::SCH_NARROW_WIDE_HIGH;

    // a word is ready once the low schedule and, with a 32-bit second operand, the high schedule have passed
    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_ready
            assign ready[g] = cnt_lo_reg >= sch_l[4*g +: 4]
                              && (!run_w2_reg || sch_h[4*g +: 4] == 4'h0
                                  || (state_reg == mma_pkg::ST_RUN
                                      && cnt_hi_reg >= sch_h[4*g +: 4]));
        end
    endgenerate

    always_comb begin
        unique case (run_mode_reg)
            mma_pkg::MODE_UMUL: sum_extension = 16'h0000;
            mma_pkg::MODE_UACC: sum_extension = {15'h0000, carry_flag_reg};
            mma_pkg::MODE_SMUL, mma_pkg::MODE_SACC: sum_extension = res_sign ? mma_pkg::SUM_EXTENSION_NEG
                                                                      : 16'h0000;
        endcase
    end

    always_comb begin
        ctrl = 16'h0000;
        ctrl[mma_pkg::CTL_DLY_EN] = dly_en_reg;
        ctrl[mma_pkg::CTL_DLY32] = dly32_reg;
        ctrl[mma_pkg::CTL_CARRY] = carry_flag_reg;
        ctrl[mma_pkg::CTL_DONE_LSB +: 5] = done_reg;
    end

    // operand and control registers, read port
    always_comb begin
        logic sx;
        logic [15:0] wval;
        logic [15:0] rval;
        sx = (first_go && !addr_high) ? op1_mode(bus_addr)[0] : mode_reg[0];
        wval = bus_byte ? {{8{sx & bus_wdata[7]}}, bus_wdata[7:0]} : bus_wdata;
        rval = 16'h0000;
        first_lo_next = first_lo_reg;
        first_hi_next = first_hi_reg;
        first_wide_next = first_wide_reg;
        mode_next = mode_reg;
        second_lo_next = second_lo_reg;
        second_hi_next = second_hi_reg;
        dly_en_next = dly_en_reg;
        dly32_next = dly32_reg;
        if (first_hi_go) begin
            first_hi_next = wval;
            first_wide_next = 1'b1;
        end else if (first_go) begin
            first_lo_next = wval;
            first_wide_next = 1'b0;
            mode_next = op1_mode(bus_addr);
        end
        if (start_go) begin
            second_lo_next = wval;
        end
        if (hi_go) begin
            second_hi_next = wval;
        end
        if (wr_go && bus_addr == mma_pkg::MULT_CONTROL) begin
            dly_en_next = bus_wdata[mma_pkg::CTL_DLY_EN];
            dly32_next = bus_wdata[mma_pkg::CTL_DLY32];
        end
        if (addr_first) begin
            rval = addr_high ? first_hi_reg : first_lo_reg;
        end else begin
            case (bus_addr)
                mma_pkg::OP2_START_16, mma_pkg::OP2_START_LOW: rval = second_lo_reg;
                mma_pkg::OP2_CONTINUE_HIGH: rval = second_hi_reg;
                mma_pkg::MULT_CONTROL: rval = ctrl;
                mma_pkg::RESULT_WORD_0, mma_pkg::COMPAT_RESULT_LOW: rval = res_reg[0];
                mma_pkg::RESULT_WORD_1, mma_pkg::COMPAT_RESULT_HIGH: rval = res_reg[1];
                mma_pkg::RESULT_WORD_2: rval = res_reg[2];
                mma_pkg::RESULT_WORD_3: rval = res_reg[3];
                mma_pkg::SUM_EXTENSION: rval = sum_extension;
                default: rval = 16'h0000;
            endcase
        end
        rdata_next = bus_rd ? rval : rdata_reg;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            first_lo_reg <= 16'h0000;
            first_hi_reg <= 16'h0000;
            first_wide_reg <= 1'b0;
            mode_reg <= mma_pkg::MODE_UMUL;
            second_lo_reg <= 16'h0000;
            second_hi_reg <= 16'h0000;
            dly_en_reg <= mma_pkg::CTL_DLY_EN_RST;
            dly32_reg <= mma_pkg::CTL_DLY32_RST;
            rdata_reg <= 16'h0000;
        end else begin
            first_lo_reg <= first_lo_next;
            first_hi_reg <= first_hi_next;
            first_wide_reg <= first_wide_next;
            mode_reg <= mode_next;
            second_lo_reg <= second_lo_next;
            second_hi_reg <= second_hi_next;
            dly_en_reg <= dly_en_next;
            dly32_reg <= dly32_next;
            rdata_reg <= rdata_next;
        end
    end

    // scheduler and result words
    always_comb begin
        state_next = state_reg;
        cnt_lo_next = cnt_lo_reg;
        cnt_hi_next = cnt_hi_reg;
        done_next = done_reg;
        carry_flag_next = carry_flag_reg;
        base_next = base_reg;
        run_mode_next = run_mode_reg;
        run_w1_next = run_w1_reg;
        run_w2_next = run_w2_reg;
        for (int i = 0; i < 4; i++) begin
            res_next[i] = res_reg[i];
            if (wr_go && (bus_addr == 5'(mma_pkg::RESULT_WORD_0 + i)
                          || (i == 0 && bus_addr == mma_pkg::COMPAT_RESULT_LOW)
                          || (i == 1 && bus_addr == mma_pkg::COMPAT_RESULT_HIGH))) begin
                res_next[i] = bus_wdata;
            end
        end
        unique case (state_reg)
            mma_pkg::ST_IDLE: begin
            end
            mma_pkg::ST_WAIT_HIGH, mma_pkg::ST_RUN: begin
                cnt_lo_next = sat_inc(cnt_lo_reg);
                if (state_reg == mma_pkg::ST_RUN) begin
                    cnt_hi_next = sat_inc(cnt_hi_reg);
                end
                for (int i = 0; i < 4; i++) begin
                    if (ready[i] && !done_reg[i]) begin
                        res_next[i] = full[16*i +: 16];
                        done_next[i] = 1'b1;
                    end
                end
                if (ready[4] && !done_reg[4]) begin
                    carry_flag_next = carry_calc;
                    done_next[4] = 1'b1;
                end
                if (&done_next) begin
                    state_next = mma_pkg::ST_IDLE;
                end
            end
            default: state_next = mma_pkg::ST_IDLE;
        endcase
        if (hi_go) begin
            state_next = mma_pkg::ST_RUN;
            cnt_hi_next = mma_pkg::CNT_START;
        end
        if (first_go && state_reg != mma_pkg::ST_IDLE) begin
            state_next = mma_pkg::ST_IDLE;
        end
        if (start_go) begin
            state_next = startlo ? mma_pkg::ST_WAIT_HIGH : mma_pkg::ST_RUN;
            cnt_lo_next = mma_pkg::CNT_START;
            cnt_hi_next = 4'h0;
            done_next = 5'h00;
            base_next = {res_reg[3], res_reg[2], res_reg[1], res_reg[0]};
            run_mode_next = mode_reg;
            run_w1_next = first_wide_reg;
            run_w2_next = startlo;
        end
        // never hold while the continuing high word is still awaited
        hold_next = dly_en_next && state_next == mma_pkg::ST_RUN
                    && !(dly32_next ? &done_next[1:0] : &done_next[3:0]);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= mma_pkg::ST_IDLE;
            cnt_lo_reg <= 4'h0;
            cnt_hi_reg <= 4'h0;
            done_reg <= 5'h00;
            carry_flag_reg <= 1'b0;
            base_reg <= 64'h0000_0000_0000_0000;
            run_mode_reg <= mma_pkg::MODE_UMUL;
            run_w1_reg <= 1'b0;
            run_w2_reg <= 1'b0;
            hold_reg <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                res_reg[i] <= 16'h0000;
            end
        end else begin
            state_reg <= state_next;
            cnt_lo_reg <= cnt_lo_next;
            cnt_hi_reg <= cnt_hi_next;
            done_reg <= done_next;
            carry_flag_reg <= carry_flag_next;
            base_reg <= base_next;
            run_mode_reg <= run_mode_next;
            run_w1_reg <= run_w1_next;
            run_w2_reg <= run_w2_next;
            hold_reg <= hold_next;
            for (int i = 0; i < 4; i++) begin
                res_reg[i] <= res_next[i];
            end
        end
    end

    assign bus_rdata = rdata_reg;
    assign bus_wait = hold_reg;

    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_start_nn;
        start16 && !first_wide_reg;
    endsequence
    sequence s_quiet4;
        quiet [*4];
    endsequence

    property p_first_no_start;
        first_go && state_reg == mma_pkg::ST_IDLE |=> state_reg == mma_pkg::ST_IDLE;
    endproperty
    a_first_no_start: assert property (p_first_no_start)
        else $error("first operand write started an operation");

    property p_width_flag;
        first_go |=> first_wide_reg == $past(addr_high);
    endproperty
    a_width_flag: assert property (p_width_flag)
        else $error("first operand width flag wrong");

    property p_high_kept;
        first_go && !addr_high |=> $stable(first_hi_reg);
    endproperty
    a_high_kept: assert property (p_high_kept)
        else $error("stored high word changed by low write");

    property p_high_ignored;
        wr_go && bus_addr == mma_pkg::OP2_CONTINUE_HIGH
            && state_reg != mma_pkg::ST_WAIT_HIGH |=> $stable(second_hi_reg) && $stable(state_reg);
    endproperty
    a_high_ignored: assert property (p_high_ignored)
        else $error("lone second high write was taken");

    property p_low_waits;
        startlo |=> state_reg == mma_pkg::ST_WAIT_HIGH && done_reg == 5'h00;
    endproperty
    a_low_waits: assert property (p_low_waits)
        else $error("second low write did not await high word");

    property p_nn_sched;
        s_start_nn ##1 s_quiet4 |-> (done_reg == 5'h13) ##1 (done_reg == 5'h1f);
    endproperty
    a_nn_sched: assert property (p_nn_sched)
        else $error("narrow result schedule wrong");

    property p_hold_stalls;
        hold_reg && bus_wr |=> $stable(second_lo_reg) && $stable(first_lo_reg);
    endproperty
    a_hold_stalls: assert property (p_hold_stalls)
        else $error("held write was taken");

    property p_hold_level;
        dly_en_reg && !dly32_reg && state_reg == mma_pkg::ST_RUN && done_reg[3:0] != 4'hf
            |-> hold_reg;
    endproperty
    a_hold_level: assert property (p_hold_level)
        else $error("write not held while result pending");

    property p_umul_carry;
        done_reg[4] && run_mode_reg == mma_pkg::MODE_UMUL |-> !carry_flag_reg;
    endproperty
    a_umul_carry: assert property (p_umul_carry)
        else $error("unsigned multiply carry not zero");

    property p_byte_sext;
        first_go && bus_byte && !addr_high && op1_mode(bus_addr)[0] && bus_wdata[7]
            |=> first_lo_reg[15:8] == 8'hff;
    endproperty
    a_byte_sext: assert property (p_byte_sext)
        else $error("signed byte write not sign extended");
endmodule
`default_nettype wire

// ===== tb/mma_cpu.sv
// cpu side of the multiplier register bus
`timescale 1ns/1ps
`default_nettype none
module mma_cpu (
    // clock
    input wire logic clk_sys,
    // register bus
    output logic [mma_pkg::ADDR_W-1:0] bus_addr,
    output logic bus_wr,
    output logic bus_rd,
    output logic bus_byte,
    output logic [15:0] bus_wdata,
    input wire logic [15:0] bus_rdata,
    input wire logic bus_wait
);
    int stalls = 0;
    initial begin
        bus_addr = '0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_byte = 1'b0;
        bus_wdata = 16'h0000;
    end
    // held until an edge without stall; strobe stays up for back-to-back writes
    task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic b);
        bus_addr <= a;
        bus_wdata <= d;
        bus_byte <= b;
        bus_wr <= 1'b1;
        bus_rd <= 1'b0;
        stalls = 0;
        @(posedge clk_sys);
        while (bus_wait === 1'b1 && stalls < 50) begin
            stalls++;
            @(posedge clk_sys);
        end
    endtask
    // released data lines carry a changing pattern
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        bus_addr <= a;
        bus_rd <= 1'b1;
        bus_wr <= 1'b0;
        bus_wdata <= ~bus_wdata;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1 d = bus_rdata;
        @(posedge clk_sys);
    endtask
    task automatic idle(input int n);
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
        bus_wdata <= ~bus_wdata;
        repeat (n) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// ===== tb/mma_core_bench.sv
// self-checking bench of the multiply-accumulate unit
`timescale 1ns/1ps
`default_nettype none
module mma_core_bench;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [mma_pkg::ADDR_W-1:0] bus_addr;
    logic bus_wr;
    logic bus_rd;
    logic bus_byte;
    logic [15:0] bus_wdata;
    logic [15:0] bus_rdata;
    logic bus_wait;
    int failures = 0;
    int n_tests = 0;
    int seed = 43;
    logic [1:0] m = 2'h0;
    logic [31:0] o1 = 32'h0000_0000;
    logic [63:0] res = 64'h0000_0000_0000_0000;
    logic hk = 1'b0;
    logic [15:0] g;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
    logic [31:0] pa;
    logic [32:0] s;
    always #5 clk_sys = ~clk_sys;
    mma_core mma_core_i (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .bus_addr(bus_addr),
        .bus_wr(bus_wr),
        .bus_rd(bus_rd),
        .bus_byte(bus_byte),
        .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata),
        .bus_wait(bus_wait)
    );
    mma_cpu mma_cpu_i (
        .clk_sys(clk_sys),
        .bus_addr(bus_addr),
        .bus_wr(bus_wr),
        .bus_rd(bus_rd),
        .bus_byte(bus_byte),
        .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata),
        .bus_wait(bus_wait)
    );
    function automatic logic [15:0] bx(logic [15:0] v, logic b, logic sg);
        return b ? {(sg && v[7]) ? 8'hff : 8'h00, v[7:0]} : v;
    endfunction
    function automatic logic [63:0] sx(logic [31:0] v, logic wd, logic sg);
        logic [63:0] u;
        u = wd ? {32'h0000_0000, v} : {48'h0000_0000_0000, v[15:0]};
        if (sg && (wd ? v[31] : v[15]))
            u = u | (wd ? 64'hffff_ffff_0000_0000 : 64'hffff_ffff_ffff_0000);
        return u;
    endfunction
    task automatic chk(input logic [15:0] gv, input logic [15:0] e);
        n_tests++;
        if (gv !== e) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, gv, e);
        end
    endtask
    task automatic rc(input logic [4:0] a, input logic [15:0] e);
        logic [15:0] v;
        mma_cpu_i.rd(a, v);
        chk(v, e);
    endtask
    task automatic rlo;
        rc(mma_pkg::RESULT_WORD_0, res[15:0]);
        rc(mma_pkg::RESULT_WORD_1, res[31:16]);
    endtask
    task automatic w(input logic [4:0] a, input logic [15:0] d, input logic b);
        mma_cpu_i.wr(a, d, b);
        if (mma_cpu_i.stalls >= 50) begin
            failures++;
            $display("mismatch at %0t: write stalled too long", $time);
            tally_and_finish();
        end
    endtask
    // 16-bit or byte operands; low-word addresses get a stale high word first
    task automatic nc(input logic [1:0] md, input logic [4:0] a1, input logic n1,
                      input logic b1, input logic b2);
        logic [63:0] p;
        x = 16'($random(seed));
        y = 16'($random(seed));
        if (n1) begin
            if (a1 >= mma_pkg::OP1_UNSIGNED_MUL_LOW)
                w(a1 + 5'h01, 16'($random(seed)), 1'b0);
            w(a1, x, b1);
            m = md;
            o1 = {16'h0000, bx(x, b1, md[0])};
        end
        w(mma_pkg::OP2_START_16, y, b2);
        rc(mma_pkg::RESULT_WORD_0, res[15:0]);
        p = sx(o1, 1'b0, m[0]) * sx({16'h0000, bx(y, b2, m[0])}, 1'b0, m[0]);
        s = m[1] ? {1'b0, res[31:0]} + {1'b0, p[31:0]} : {1'b0, p[31:0]};
        res[31:0] = s[31:0];
        hk = 1'b0;
        mma_cpu_i.idle(1);
        rc(mma_pkg::COMPAT_RESULT_LOW, res[15:0]);
        rc(mma_pkg::COMPAT_RESULT_HIGH, res[31:16]);
        rlo();
        rc(mma_pkg::SUM_EXTENSION, m == 2'h0 ? 16'h0000 : m == 2'h2 ?
            {15'h0, s[32]} : {16{s[31]}});
        mma_cpu_i.rd(mma_pkg::MULT_CONTROL, g);
        if (m != 2'h3)
            chk({15'h0, g[mma_pkg::CTL_CARRY]}, {15'h0, m[1] ? s[32] : m[0] & s[31]});
    endtask
    // 32-bit operands, optional byte high word for 24 bits
    task automatic wc(input logic md, input logic hb);
        logic [15:0] v [4];
        logic [63:0] p;
        foreach (v[i]) v[i] = 16'($random(seed));
        w(mma_pkg::OP1_UNSIGNED_MUL_LOW + {3'h0, md, 1'b0}, v[0], 1'b0);
        w(mma_pkg::OP1_UNSIGNED_MUL_HIGH + {3'h0, md, 1'b0}, v[1], hb);
        w(mma_pkg::OP2_START_LOW, v[2], 1'b0);
        w(mma_pkg::OP2_CONTINUE_HIGH, v[3], 1'b0);
        m = {1'b0, md};
        o1 = {bx(v[1], hb, md), v[0]};
        p = sx(o1, 1'b1, md) * sx({v[3], v[2]}, 1'b1, md);
        mma_cpu_i.idle(8);
        if (hk)
            rc(mma_pkg::RESULT_WORD_3, res[63:48]);
        mma_cpu_i.idle(1);
        res = p;
        hk = 1'b1;
        for (int i = 0; i < 4; i++)
            rc(mma_pkg::RESULT_WORD_0 + 5'(i), res[16*i +: 16]);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rlo();
        rc(5'h1f, 16'h0000);
        mma_cpu_i.rd(mma_pkg::MULT_CONTROL, g);
        chk(g & 16'h0007, 16'h0000);
        $display("reset test done");
        for (int j = 0; j < 4; j++)
            wc(j[0], j[1]);
        $display("wide test done");
        for (int i = 0; i < 24; i++)
            nc(2'(i), i % 8 < 4 ? mma_pkg::OP1_UNSIGNED_MUL_16 + 5'(i % 4) :
                mma_pkg::OP1_UNSIGNED_MUL_LOW + 5'(2 * (i % 4)), i % 3 != 2,
                1'($random(seed)), 1'($random(seed)));
        $display("narrow test done");
        w(mma_pkg::OP2_CONTINUE_HIGH, 16'($random(seed)), 1'b0);
        mma_cpu_i.idle(12);
        rlo();
        $display("lone high test done");
        // k=0 second start aborts the first, k=1,2 hold it off
        for (int k = 0; k < 3; k++) begin
            x = 16'($random(seed));
            y = 16'($random(seed));
            z = 16'($random(seed));
            w(mma_pkg::MULT_CONTROL, k == 0 ? 16'h0000 : {14'h0, k == 2, 1'b1}, 1'b0);
            mma_cpu_i.rd(mma_pkg::MULT_CONTROL, g);
            chk(g & 16'h0003, k == 0 ? 16'h0000 : {14'h0, k == 2, 1'b1});
            w(mma_pkg::OP1_UNSIGNED_ACC_16, x, 1'b0);
            w(mma_pkg::OP2_START_16, y, 1'b0);
            mma_cpu_i.idle(1);
            w(mma_pkg::OP2_START_16, z, 1'b0);
            chk({15'h0, mma_cpu_i.stalls > 0}, {15'h0, k != 0});
            pa = {16'h0000, x} * {16'h0000, y};
            s = {1'b0, res[31:0]} + (k == 0 ? 33'h0 : {1'b0, pa});
            pa = {16'h0000, x} * {16'h0000, z};
            s = s + {1'b0, pa};
            res[31:0] = s[31:0];
            m = 2'h2;
            o1 = {16'h0000, x};
            mma_cpu_i.idle(5);
            rlo();
            w(mma_pkg::MULT_CONTROL, 16'h0000, 1'b0);
        end
        $display("abort and delay test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
